//--- logic/flash_front_end_pkg.sv
// Operation
// - Status, and buffer commands on a buffer not in use, work while busy.
// - All commands, addresses, data enter on input.
// - Sample on rising, drive on falling edge.
// - Deselected: ignore input, output released.
// - Select fall starts, select rise ends command.
// - Write protect low guards lowest 256 pages.
// - Reset pin aborts work and holds idle.
// - Ready pin pulled low during self-timed work.
// - Busy blocks array and busy buffer only.
// - After reset: clock idles high, output off.
// - Each select fall samples clock idle level.
// - Read opcodes come in two mode variants.
// - Program, erase, auxiliary opcodes in any mode.
// - Program with erase: 83H, 86H.
// - Program without erase: 88H, 89H.
// - Program through buffer: 82H, 85H.
// - Page to buffer transfer: 53H, 55H.
// - Page to buffer compare: 60H, 61H.
// - Auto page rewrite: 58H, 59H.
// - Header: three reserved, twelve page, nine byte.
// - Compare result lands in status bit 6.
package flash_front_end_pkg;

    // ****************************************************
    // Opcodes, first the polarity form then the SPI form.
    // ****************************************************
    localparam logic [7:0] OP_CONT_RD_P = 8'h68, OP_CONT_RD_S = 8'hE8;
    localparam logic [7:0] OP_PAGE_RD_P = 8'h52, OP_PAGE_RD_S = 8'hD2;
    localparam logic [7:0] OP_BUF1_RD_P = 8'h54, OP_BUF1_RD_S = 8'hD4;
    localparam logic [7:0] OP_BUF2_RD_P = 8'h56, OP_BUF2_RD_S = 8'hD6;
    localparam logic [7:0] OP_STATUS_P = 8'h57, OP_STATUS_S = 8'hD7;
    localparam logic [7:0] OP_BUF1_WR = 8'h84, OP_BUF2_WR = 8'h87;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81, OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OP_PROG_E1 = 8'h83, OP_PROG_E2 = 8'h86;
    localparam logic [7:0] OP_PROG_N1 = 8'h88, OP_PROG_N2 = 8'h89;
    localparam logic [7:0] OP_PROG_T1 = 8'h82, OP_PROG_T2 = 8'h85;
    localparam logic [7:0] OP_XFER1 = 8'h53, OP_XFER2 = 8'h55;
    localparam logic [7:0] OP_CMP1 = 8'h60, OP_CMP2 = 8'h61;
    localparam logic [7:0] OP_REWR1 = 8'h58, OP_REWR2 = 8'h59;

    // ****************************************************
    // Geometry, counts, status layout and reset values.
    // ****************************************************
    localparam int BUF_BYTES = 264;
    localparam logic [8:0] BUF_LAST = 9'h107;
    localparam logic [11:0] PROT_LIMIT = 12'h100;
    localparam logic [5:0] OPC_LAST_BIT = 6'h07;
    localparam logic [5:0] HDR_LAST_BIT = 6'h1F;
    localparam logic [5:0] DUMMY_LAST_ARRAY = 6'h1F;
    localparam logic [5:0] DUMMY_LAST_BUF = 6'h07;
    localparam int STAT_RDY_POS = 7;
    localparam int STAT_CMP_POS = 6;
    // Low status bits; the value is arbitrary.
    localparam logic [5:0] STATUS_LOW = 6'h0A;
    localparam logic CLK_IDLE_RESET = 1'b1;
    localparam logic [4:0] PIN_RESET = 5'h03;

    // Command kinds after decoding.
    typedef enum logic [3:0] {
        CMD_NONE, CMD_CONT_RD, CMD_PAGE_RD, CMD_BUF_RD, CMD_STATUS,
        CMD_BUF_WR, CMD_PROG_E, CMD_PROG_N, CMD_PROG_T, CMD_XFER,
        CMD_CMP, CMD_REWRITE, CMD_PAGE_ERASE, CMD_BLOCK_ERASE
    } cmd_t;

    // Maps an opcode to its command kind.
    function automatic cmd_t op_kind(input logic [7:0] op);
        unique case (op)
            OP_CONT_RD_P, OP_CONT_RD_S: return CMD_CONT_RD;
            OP_PAGE_RD_P, OP_PAGE_RD_S: return CMD_PAGE_RD;
            OP_BUF1_RD_P, OP_BUF1_RD_S, OP_BUF2_RD_P, OP_BUF2_RD_S: return CMD_BUF_RD;
            OP_STATUS_P, OP_STATUS_S: return CMD_STATUS;
            OP_BUF1_WR, OP_BUF2_WR: return CMD_BUF_WR;
            OP_PROG_E1, OP_PROG_E2: return CMD_PROG_E;
            OP_PROG_N1, OP_PROG_N2: return CMD_PROG_N;
            OP_PROG_T1, OP_PROG_T2: return CMD_PROG_T;
            OP_XFER1, OP_XFER2: return CMD_XFER;
            OP_CMP1, OP_CMP2: return CMD_CMP;
            OP_REWR1, OP_REWR2: return CMD_REWRITE;
            OP_PAGE_ERASE: return CMD_PAGE_ERASE;
            OP_BLOCK_ERASE: return CMD_BLOCK_ERASE;
            default: return CMD_NONE;
        endcase
    endfunction : op_kind

    // Tells whether an opcode addresses the second buffer.
    function automatic logic op_buf2(input logic [7:0] op);
        return op inside {OP_BUF2_RD_P, OP_BUF2_RD_S, OP_BUF2_WR, OP_PROG_E2,
            OP_PROG_N2, OP_PROG_T2, OP_XFER2, OP_CMP2, OP_REWR2};
    endfunction : op_buf2

    // Kinds that start a self-timed array operation.
    function automatic logic launches(input cmd_t k);
        return k inside {CMD_PROG_E, CMD_PROG_N, CMD_PROG_T, CMD_XFER,
            CMD_CMP, CMD_REWRITE, CMD_PAGE_ERASE, CMD_BLOCK_ERASE};
    endfunction : launches

    // Kinds that alter array contents.
    function automatic logic programs(input cmd_t k);
        return launches(k) && k != CMD_XFER && k != CMD_CMP;
    endfunction : programs

    // Kinds that use the array in any way.
    function automatic logic is_array(input cmd_t k);
        return launches(k) || k == CMD_CONT_RD || k == CMD_PAGE_RD;
    endfunction : is_array

endpackage : flash_front_end_pkg

//--- logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Asynchronous inputs and their synchronised copies.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // Two flip-flops per bit; the first is read only by the second.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    meta[i] <= INIT[i];
                    q[i] <= INIT[i];
                end else begin
                    meta[i] <= d[i];
                    q[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync
`default_nettype wire

//--- logic/buffer_ram.sv
`timescale 1ns/1ps
`default_nettype none
module buffer_ram
    import flash_front_end_pkg::*;
(
    // Clock.
    input wire logic clock,
    // Front-end port.
    input wire logic a_buf2,
    input wire logic [8:0] a_addr,
    input wire logic a_we,
    input wire logic [7:0] a_wdata,
    output logic [7:0] a_rdata,
    // Array-engine port.
    input wire logic b_buf2,
    input wire logic [8:0] b_addr,
    input wire logic b_we,
    input wire logic [7:0] b_wdata,
    output logic [7:0] b_rdata
);

    logic [7:0] mem [0:2*BUF_BYTES-1];

    // Places the second buffer right after the first.
    function automatic logic [9:0] index(input logic b2, input logic [8:0] a);
        return b2 ? 10'(a) + 10'(BUF_BYTES) : 10'(a);
    endfunction : index

    // Two ports; read data always come from a register.
    always_ff @(posedge clock) begin
        if (a_we) begin
            mem[index(a_buf2, a_addr)] <= a_wdata;
        end
        if (b_we) begin
            mem[index(b_buf2, b_addr)] <= b_wdata;
        end
        a_rdata <= mem[index(a_buf2, a_addr)];
        b_rdata <= mem[index(b_buf2, b_addr)];
    end

endmodule : buffer_ram
`default_nettype wire

//--- logic/serial_flash_command_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_front_end
    import flash_front_end_pkg::*;
(
    // System clock and power-on reset.
    input wire logic clock,
    input wire logic rst_n,
    // Serial link from the host.
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so_out,
    output logic so_oe_n,
    // Protect and reset pins.
    input wire logic wp_n,
    input wire logic reset_pin_n,
    // Open-drain ready/busy pin.
    output logic rdy_out,
    output logic rdy_oe_n,
    // Array engine requests.
    output logic array_start,
    output var cmd_t array_op,
    output logic [11:0] array_page,
    output logic [8:0] array_byte,
    output logic array_buf2,
    output logic array_read,
    output logic array_rd_next,
    input wire logic [7:0] array_rd_byte,
    input wire logic array_done,
    input wire logic array_match,
    // Array engine access to the busy buffer.
    input wire logic [8:0] back_addr,
    input wire logic back_we,
    input wire logic [7:0] back_wdata,
    output logic [7:0] back_rdata,
    // Clocking mode seen at the last select fall.
    output logic clk_idle_high
);

    // ****************************************************
    // Pin synchronisation and edge detection.
    // ****************************************************
    typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_DUMMY, ST_WRITE, ST_READ, ST_SKIP} st_t;

    logic [4:0] pins_s;
    logic cs_s;
    logic sck_s;
    logic si_s;
    logic wp_s;
    logic cs_d;
    logic sck_d;
    logic core_rst_n;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;

    pin_sync #(
        .WIDTH(5),
        .INIT(PIN_RESET)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({reset_pin_n, wp_n, si, sck, cs_n}),
        .q(pins_s)
    );

    assign cs_s = pins_s[0];
    assign sck_s = pins_s[1];
    assign si_s = pins_s[2];
    assign wp_s = pins_s[3];

    // The reset pin, once synchronised, holds the whole controller idle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_rst_n <= 1'b0;
        end else begin
            core_rst_n <= pins_s[4];
        end
    end

    // Previous levels of select and serial clock for edge finding.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cs_d <= 1'b1;
            sck_d <= CLK_IDLE_RESET;
        end else begin
            cs_d <= cs_s;
            sck_d <= sck_s;
        end
    end

    // Edges count only while selected, so a deselected link is ignored.
    assign cs_fall = cs_d && !cs_s;
    assign cs_rise = !cs_d && cs_s;
    assign sck_rise = sck_s && !sck_d && !cs_s;
    assign sck_fall = !sck_s && sck_d && !cs_s;

    // ****************************************************
    // Command state.
    // ****************************************************
    st_t state;
    logic [5:0] bit_cnt;
    logic [30:0] hdr;
    logic [31:0] next_hdr;
    cmd_t kind;
    logic buf2;
    logic [11:0] page;
    logic [8:0] baddr;
    logic armed;
    logic wr_pulse;
    logic [7:0] wr_data;
    logic blocked;
    logic wp_block;
    logic [5:0] dummy_last;
    logic busy;
    cmd_t busy_op;
    logic busy_buf2;
    logic busy_has_buf;
    logic cmp_match;
    logic [7:0] status;
    logic [7:0] ram_rdata;
    logic [7:0] src;
    logic [6:0] out_sr;
    logic [2:0] out_cnt;
    logic so_live;
    logic rd_adv;

    // Every bit enters on the input pin, first bit highest.
    assign next_hdr = {hdr, si_s};

    // Array work is refused while busy, and so is the buffer in use.
    assign blocked = busy && (is_array(kind) || ((kind == CMD_BUF_RD || kind == CMD_BUF_WR)
        && busy_has_buf && buf2 == busy_buf2));

    // Low pages cannot be altered while protect is low.
    assign wp_block = !wp_s && programs(kind) && page < PROT_LIMIT;

    assign dummy_last = (kind == CMD_BUF_RD) ? DUMMY_LAST_BUF : DUMMY_LAST_ARRAY;

    // Command sequencer running on serial clock rising edges.
    always_ff @(posedge clock or negedge core_rst_n) begin
        if (!core_rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= '0;
            hdr <= '0;
            kind <= CMD_NONE;
            buf2 <= 1'b0;
            page <= '0;
            armed <= 1'b0;
            wr_pulse <= 1'b0;
            wr_data <= '0;
        end else begin
            wr_pulse <= 1'b0;
            if (cs_s) begin
                state <= ST_IDLE;
            end else if (cs_fall) begin
                state <= ST_HDR;
                bit_cnt <= '0;
                armed <= 1'b0;
            end else if (sck_rise) begin
                hdr <= next_hdr[30:0];
                bit_cnt <= bit_cnt + 6'h01;
                unique case (state)
                    ST_HDR: begin
                        if (bit_cnt == OPC_LAST_BIT) begin
                            kind <= op_kind(next_hdr[7:0]);
                            buf2 <= op_buf2(next_hdr[7:0]);
                            if (op_kind(next_hdr[7:0]) == CMD_STATUS) begin
                                state <= ST_READ;
                            end else if (op_kind(next_hdr[7:0]) == CMD_NONE) begin
                                state <= ST_SKIP;
                            end
                        end
                        if (bit_cnt == HDR_LAST_BIT) begin
                            bit_cnt <= '0;
                            if (kind != CMD_BUF_RD && kind != CMD_BUF_WR) begin
                                page <= next_hdr[20:9];
                            end
                            armed <= !blocked;
                            if (blocked) begin
                                state <= ST_SKIP;
                            end else if (kind inside {CMD_CONT_RD, CMD_PAGE_RD, CMD_BUF_RD}) begin
                                state <= ST_DUMMY;
                            end else if (kind == CMD_BUF_WR || kind == CMD_PROG_T) begin
                                state <= ST_WRITE;
                            end else begin
                                state <= ST_SKIP;
                            end
                        end
                    end
                    ST_DUMMY: begin
                        if (bit_cnt == dummy_last) begin
                            state <= ST_READ;
                        end
                    end
                    ST_WRITE: begin
                        if (bit_cnt[2:0] == 3'h7) begin
                            wr_pulse <= 1'b1;
                            wr_data <= next_hdr[7:0];
                        end
                    end
                    ST_IDLE, ST_READ, ST_SKIP: begin
                    end
                endcase
            end
        end
    end

    // Buffer byte pointer: loaded from the header, wraps at the buffer end.
    always_ff @(posedge clock or negedge core_rst_n) begin
        if (!core_rst_n) begin
            baddr <= '0;
        end else if (sck_rise && state == ST_HDR && bit_cnt == HDR_LAST_BIT) begin
            baddr <= next_hdr[8:0];
        end else if (wr_pulse || rd_adv) begin
            baddr <= (baddr == BUF_LAST) ? 9'h000 : baddr + 9'h001;
        end
    end

    // Clocking mode: mode 3 after reset, resampled at each select fall.
    always_ff @(posedge clock or negedge core_rst_n) begin
        if (!core_rst_n) begin
            clk_idle_high <= CLK_IDLE_RESET;
        end else if (cs_fall) begin
            clk_idle_high <= sck_s;
        end
    end

    // ****************************************************
    // Self-timed operations and the ready/busy pin.
    // ****************************************************

    // Launches array work at select rise and retires it on completion.
    always_ff @(posedge clock or negedge core_rst_n) begin
        if (!core_rst_n) begin
            busy <= 1'b0;
            busy_op <= CMD_NONE;
            busy_buf2 <= 1'b0;
            busy_has_buf <= 1'b0;
            array_start <= 1'b0;
            cmp_match <= 1'b0;
        end else begin
            array_start <= 1'b0;
            if (busy && array_done) begin
                busy <= 1'b0;
                if (busy_op == CMD_CMP) begin
                    cmp_match <= array_match;
                end
            end
            if (cs_rise && armed && launches(kind) && !wp_block) begin
                busy <= 1'b1;
                busy_op <= kind;
                busy_buf2 <= buf2;
                busy_has_buf <= kind != CMD_PAGE_ERASE && kind != CMD_BLOCK_ERASE;
                array_start <= 1'b1;
            end
        end
    end

    // Open drain: driven low only during self-timed work.
    assign rdy_out = 1'b0;
    assign rdy_oe_n = !busy;

    assign array_op = busy_op;
    assign array_buf2 = busy_buf2;
    assign array_page = page;
    assign array_byte = baddr;
    assign array_read = state == ST_READ && (kind == CMD_CONT_RD || kind == CMD_PAGE_RD);

    // ****************************************************
    // Buffers and serial output.
    // ****************************************************
    buffer_ram u_ram (
        .clock(clock),
        .a_buf2(buf2),
        .a_addr(baddr),
        .a_we(wr_pulse),
        .a_wdata(wr_data),
        .a_rdata(ram_rdata),
        .b_buf2(busy_buf2),
        .b_addr(back_addr),
        .b_we(back_we),
        .b_wdata(back_wdata),
        .b_rdata(back_rdata)
    );

    // Status byte: ready flag, compare result, fixed low bits.
    always_comb begin
        status = {2'b00, STATUS_LOW};
        status[STAT_RDY_POS] = !busy;
        status[STAT_CMP_POS] = cmp_match;
    end

    // Byte source for the read in progress.
    assign src = (kind == CMD_STATUS) ? status : (kind == CMD_BUF_RD) ? ram_rdata : array_rd_byte;

    // Shifts bytes out on serial clock falling edges.
    always_ff @(posedge clock or negedge core_rst_n) begin
        if (!core_rst_n) begin
            so_out <= 1'b0;
            out_sr <= '0;
            out_cnt <= '0;
            so_live <= 1'b0;
            rd_adv <= 1'b0;
            array_rd_next <= 1'b0;
        end else begin
            rd_adv <= 1'b0;
            array_rd_next <= 1'b0;
            if (state != ST_READ) begin
                so_live <= 1'b0;
                out_cnt <= '0;
            end else if (sck_fall) begin
                so_live <= 1'b1;
                out_cnt <= out_cnt + 3'h1;
                if (out_cnt == 3'h0) begin
                    so_out <= src[7];
                    out_sr <= src[6:0];
                    rd_adv <= kind == CMD_BUF_RD;
                    array_rd_next <= array_read;
                end else begin
                    so_out <= out_sr[6];
                    out_sr <= {out_sr[5:0], 1'b0};
                end
            end
        end
    end

    // Output released whenever deselected or not reading.
    assign so_oe_n = !so_live || cs_s;

endmodule : serial_flash_command_front_end
`default_nettype wire

//--- verification/flash_front_end_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Port checker.
// ****************************************************
module flash_front_end_asserts
    import flash_front_end_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Link and pins.
    input wire logic cs_n,
    input wire logic sck,
    input wire logic so_out,
    input wire logic so_oe_n,
    input wire logic reset_pin_n,
    input wire logic rdy_oe_n,
    // Engine side.
    input wire logic array_start,
    input wire logic array_read,
    input wire logic array_rd_next,
    input wire logic array_done,
    input wire logic clk_idle_high
);
    // All checks: system clock, power-on reset.
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_oe_selected: assert property (
        !so_oe_n |-> !$past(cs_n, 2)) else $error("output on while deselected");
    a_oe_idle: assert property (
        cs_n [*3] |-> so_oe_n) else $error("output kept after deselect");
    a_edge_out: assert property (
        !so_oe_n && $changed(so_out) |-> (!$past(sck, 2) && $past(sck, 3)) || (!$past(sck, 3) && $past(sck, 4)))
        else $error("output off clock fall");
    a_mode_take: assert property (
        $fell(cs_n) |-> ##4 (clk_idle_high == $past(sck, 4))) else $error("mode not sampled");
    a_start_busy: assert property (
        array_start |-> ##[0:1] !rdy_oe_n) else $error("launch without busy");
    a_busy_hold: assert property (
        reset_pin_n [*4] ##0 (!rdy_oe_n && !array_done) |=> !rdy_oe_n) else $error("busy dropped early");
    a_done_free: assert property (
        array_done && !rdy_oe_n |=> rdy_oe_n) else $error("busy kept after done");
    a_busy_block: assert property (
        !rdy_oe_n && !$past(rdy_oe_n) |-> !array_start) else $error("launch while busy");
    a_pin_abort: assert property (
        !reset_pin_n |-> ##[1:3] (rdy_oe_n && so_oe_n && clk_idle_high)) else $error("reset pin not obeyed");
    a_rd_pulse: assert property (
        array_rd_next |-> array_read ##1 !array_rd_next) else $error("bad read fetch pulse");
endmodule : flash_front_end_asserts

bind serial_flash_command_front_end flash_front_end_asserts u_asserts (.clock, .rst_n, .cs_n, .sck, .so_out,
    .so_oe_n, .reset_pin_n, .rdy_oe_n, .array_start, .array_read, .array_rd_next, .array_done, .clk_idle_high);
`default_nettype wire

//--- verification/host_link.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Host link model.
// ****************************************************
module host_link (
    // Bench clock.
    input wire logic clock,
    // Link pins.
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so_out
);
    logic [7:0] rx = 8'h00;
    logic idle = 1'b1;

    // Rest: deselected, clock high.
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        si = 1'b0;
    end

    // Waits n falling clock edges.
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick

    // Data moves on the fall, is taken on the rise.
    task automatic shift(input logic b);
        tick(1);
        sck = 1'b0;
        si = b;
        tick(4);
        sck = 1'b1;
        rx = {rx[6:0], so_out};
        tick(3);
    endtask : shift

    // The clock settles at its rest level before select falls.
    task automatic sel(input logic lvl);
        idle = lvl;
        sck = lvl;
        tick(4);
        cs_n = 1'b0;
        tick(4);
    endtask : sel

    // Clock to rest, select rises, data toggles.
    task automatic desel();
        tick(4);
        sck = idle;
        tick(4);
        cs_n = 1'b1;
        si = ~si;
        tick(8);
    endtask : desel

    // Opcode, address, dummies, MSB first.
    task automatic send(input logic [7:0] op, input logic [23:0] adr, input int nadr, input int ndum);
        for (int i = 7; i >= 0; i--) shift(op[i]);
        for (int i = 23; i >= 24 - nadr; i--) shift(adr[i]);
        repeat (ndum) shift(1'b0);
    endtask : send

    // One byte each way.
    task automatic xb(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) shift(w[i]);
    endtask : xb
endmodule : host_link
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Front-end bench.
// ****************************************************
module testbench
    import flash_front_end_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n, wp_n, reset_pin_n, cs_n, sck, si, so_out, so_oe_n, so_line, rdy_out, rdy_oe_n, rdy_line;
    logic array_start, array_buf2, array_read, array_done, array_match, clk_idle_high;
    logic [11:0] array_page;
    cmd_t array_op;
    int starts = 0, cycles = 0, errors = 0, checks = 0, n0;
    logic [7:0] ops [14] = '{OP_PROG_E1, OP_PROG_E2, OP_PROG_N1, OP_PROG_N2, OP_PROG_T1, OP_PROG_T2,
        OP_XFER1, OP_XFER2, OP_CMP1, OP_CMP2, OP_REWR1, OP_REWR2, OP_PAGE_ERASE, OP_BLOCK_ERASE};
    logic [7:0] rd_ops [4] = '{OP_PAGE_RD_P, OP_CONT_RD_P, OP_BUF1_RD_P, OP_BUF2_RD_P};

    // Released so toggles; ready has a pull-up.
    assign so_line = so_oe_n ? clock : so_out;
    assign rdy_line = rdy_oe_n ? 1'b1 : rdy_out;

    serial_flash_command_front_end dut (.clock, .rst_n, .cs_n, .sck, .si, .so_out, .so_oe_n, .wp_n,
        .reset_pin_n, .rdy_out, .rdy_oe_n, .array_start, .array_op, .array_page, .array_byte(), .array_buf2,
        .array_read, .array_rd_next(), .array_rd_byte(8'hA5), .array_done, .array_match,
        .back_addr(array_page[8:0]), .back_we(1'b0), .back_wdata(array_page[7:0]), .back_rdata(), .clk_idle_high);
    host_link host (.clock, .cs_n, .sck, .si, .so_out(so_line));

    always #10 clock = ~clock;

    // Launch count and timeout.
    always @(posedge clock) begin
        cycles++;
        if (array_start === 1'b1) starts++;
        if (cycles == 60000) begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Engine ends the op.
    task automatic finish_op(input logic m);
        host.tick(1);
        array_match = m;
        array_done = 1'b1;
        host.tick(1);
        array_done = 1'b0;
        host.tick(1);
    endtask : finish_op

    task automatic frame(input logic [7:0] op, input logic [11:0] pg, input logic lvl);
        host.sel(lvl);
        host.send(op, {3'b000, pg, 9'h000}, 24, 0);
        host.desel();
    endtask : frame

    task automatic stat(input logic lvl);
        host.sel(lvl);
        host.xb(lvl ? OP_STATUS_S : OP_STATUS_P);
        host.xb(8'h00);
        host.desel();
    endtask : stat

    task automatic buf_wr(input logic [7:0] op, input logic [7:0] d);
        host.sel(1'b1);
        host.send(op, 24'h00_0010, 24, 0);
        host.xb(d);
        host.desel();
    endtask : buf_wr

    task automatic t_launch();
        for (int i = 0; i < 14; i++) begin
            n0 = starts;
            frame(ops[i], 12'h348, i[1]);
            chk(12'(starts - n0), 12'h001);
            chk(12'(array_op), 12'((i < 12) ? CMD_PROG_E + i / 2 : i));
            chk(array_page, 12'h348);
            if (i < 12) chk(12'(array_buf2), 12'(i % 2));
            chk(12'(rdy_line), 12'h000);
            finish_op(1'b0);
            chk(12'(rdy_line), 12'h001);
        end
    endtask : t_launch

    task automatic t_busy();
        frame(OP_CMP1, 12'h348, 1'b1);
        stat(1'b0);
        chk(12'(host.rx), 12'h00A);
        chk(12'(clk_idle_high), 12'h000);
        n0 = starts;
        frame(OP_XFER1, 12'h348, 1'b1);
        chk(12'(starts - n0), 12'h000);
        buf_wr(OP_BUF2_WR, 8'h3C);
        host.sel(1'b0);
        host.send(OP_BUF2_RD_S, 24'h00_0010, 24, 8);
        host.xb(8'h00);
        host.desel();
        chk(12'(host.rx), 12'h03C);
        finish_op(1'b1);
        stat(1'b1);
        chk(12'(host.rx), 12'h0CA);
    endtask : t_busy

    task automatic t_reads();
        buf_wr(OP_BUF1_WR, 8'h5A);
        for (int i = 0; i < 8; i++) begin
            host.sel(i[0]);
            host.send(rd_ops[i / 2] | {i[0], 7'h00}, {3'b000, 12'h348, 9'h010}, 24, (i < 4) ? 32 : 8);
            host.xb(8'h00);
            if (i < 4) chk(12'(array_read), 12'h001);
            host.desel();
            chk(12'(host.rx), (i < 4) ? 12'h0A5 : ((i < 6) ? 12'h05A : 12'h03C));
        end
    endtask : t_reads

    task automatic t_prot();
        wp_n = 1'b0;
        n0 = starts;
        frame(OP_PROG_E1, 12'h0FF, 1'b1);
        chk(12'(starts - n0), 12'h000);
        frame(OP_PAGE_ERASE, 12'h100, 1'b1);
        chk(12'(starts - n0), 12'h001);
        finish_op(1'b0);
        wp_n = 1'b1;
        frame(OP_PROG_E1, 12'h0FF, 1'b1);
        chk(12'(starts - n0), 12'h002);
        finish_op(1'b0);
    endtask : t_prot

    task automatic t_reset();
        frame(OP_REWR2, 12'h348, 1'b0);
        chk(12'(rdy_line), 12'h000);
        reset_pin_n = 1'b0;
        host.tick(4);
        chk(12'(rdy_line), 12'h001);
        chk(12'(clk_idle_high), 12'h001);
        chk(12'(so_oe_n), 12'h001);
        reset_pin_n = 1'b1;
        host.tick(6);
        stat(1'b1);
        chk(12'(host.rx[7]), 12'h001);
    endtask : t_reset

    task automatic end_sim();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // Reset, then the scenarios.
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        reset_pin_n = 1'b1;
        array_done = 1'b0;
        array_match = 1'b0;
        host.tick(2);
        rst_n = 1'b1;
        host.tick(5);
        chk(12'(rdy_line), 12'h001);
        chk(12'(so_oe_n), 12'h001);
        chk(12'(clk_idle_high), 12'h001);
        t_launch();
        t_busy();
        t_reads();
        t_prot();
        t_reset();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
